// >>> verilog/cst_top.sv
// cst_top: cap sense oscillator routing to timer0 or timer1 with an ahb-lite slave
// assumes the oscillator and gate arrive asynchronously from pins; one clock hclk
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns

// Summary of operation
// - timer0 counts oscillator when timer0 select set and timer0 clock source clear.
// - timer1 counts oscillator when its clock source field equals binary 11.
// - timer1 off when on is 0; free with gate off; gated otherwise.
// - all control register bits clear at every reset.
// - bits 6 to 4 read zero and ignore writes.
// - bit 7 turns the sensing module on or off.
// - bits 3-2 select oscillator off, low, medium or high current.
// - read-only bit 1 reads 1 sourcing, 0 sinking, and 0 whenever the oscillator is off.
module cst_top #(
  parameter int T0_W = 8,
  parameter int T1_W = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_in,
  input  wire logic        osc_sourcing,
  input  wire logic        t1_gate_in,
  output logic             sense_module_enable,
  output logic      [1:0]  osc_current_range
);
  // refuse widths that the 32-bit read path cannot carry
  if (T0_W < 1 || T0_W > 32 || T1_W < 1 || T1_W > 32) begin
    $error("timer widths must be 1 to 32");
  end

  logic [7:0]      cap_sense_control0_ff;
  logic [4:0]      timer_cfg_ff;
  logic [T0_W-1:0] timer0_ff;
  logic [T1_W-1:0] timer1_ff;
  logic [2:0]      osc_sync_ff;
  logic [1:0]      dir_sync_ff;
  logic [1:0]      gate_sync_ff;
  logic            wr_pend_ff;
  logic [7:0]      wr_addr_ff;
  logic [31:0]     hrdata_ff;

  // input synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_sync_ff  <= 3'h0;
      dir_sync_ff  <= 2'h0;
      gate_sync_ff <= 2'h0;
    end else begin
      osc_sync_ff  <= {osc_sync_ff[1:0], osc_in};
      dir_sync_ff  <= {dir_sync_ff[0], osc_sourcing};
      gate_sync_ff <= {gate_sync_ff[0], t1_gate_in};
    end
  end

  // oscillator edge and timer routing
  wire osc_rise   = osc_sync_ff[1] & ~osc_sync_ff[2];
  wire mod_on     = cap_sense_control0_ff[cst_pkg::ENABLE_BIT];
  wire osc_run    = mod_on && (cap_sense_control0_ff[cst_pkg::RANGE_HI:cst_pkg::RANGE_LO]
                    != cst_pkg::RANGE_OFF);
  wire t0_use_osc = cap_sense_control0_ff[cst_pkg::T0_SEL_BIT] &&
                    !timer_cfg_ff[cst_pkg::T0_CS_BIT];
  wire t1_use_osc = timer_cfg_ff[cst_pkg::T1_CS_HI:cst_pkg::T1_CS_LO]
                    == cst_pkg::T1_CS_OSC;
  wire t1_on      = timer_cfg_ff[cst_pkg::T1_ON_BIT];
  wire t1_ge      = timer_cfg_ff[cst_pkg::T1_GE_BIT];
  wire t1_allow   = t1_on && (!t1_ge || gate_sync_ff[1]);
  wire t0_tick    = osc_run && osc_rise && t0_use_osc;
  wire t1_tick    = osc_run && osc_rise && t1_use_osc && t1_allow;
  wire dir_status = osc_run & dir_sync_ff[1];

  // ahb decode; write data lands the cycle after the address phase
  wire        addr_ok  = hsel && hready && (htrans == cst_pkg::HTRANS_NONSEQ ||
                         htrans == cst_pkg::HTRANS_SEQ);
  wire        wr_req   = addr_ok && hwrite;
  wire        rd_req   = addr_ok && !hwrite;
  wire [7:0]  a_ofs    = haddr[7:0];
  wire        wr_ctrl  = wr_pend_ff && (wr_addr_ff == cst_pkg::CTRL0_OFS);
  wire        wr_tcfg  = wr_pend_ff && (wr_addr_ff == cst_pkg::TIMER_CFG_OFS);
  wire        wr_t0    = wr_pend_ff && (wr_addr_ff == cst_pkg::TIMER0_OFS);
  wire        wr_t1    = wr_pend_ff && (wr_addr_ff == cst_pkg::TIMER1_OFS);
  wire [7:0]  ctrl_rd  = (cap_sense_control0_ff & cst_pkg::CTRL0_WR_MASK) |
                         (8'(dir_status) << cst_pkg::DIR_BIT);
  wire [31:0] t0_ext   = 32'(timer0_ff);
  wire [31:0] t1_ext   = 32'(timer1_ff);
  wire [31:0] rd_mux   = (a_ofs == cst_pkg::CTRL0_OFS)     ? {24'h00_0000, ctrl_rd} :
                         (a_ofs == cst_pkg::TIMER_CFG_OFS) ? {27'h000_0000, timer_cfg_ff} :
                         (a_ofs == cst_pkg::TIMER0_OFS)    ? t0_ext :
                         (a_ofs == cst_pkg::TIMER1_OFS)    ? t1_ext : 32'h0000_0000;

  // bus phase tracking; zero wait states, unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= wr_req;
      if (wr_req) begin
        wr_addr_ff <= a_ofs;
      end
      if (rd_req) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // control registers; only implemented bits store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_sense_control0_ff <= cst_pkg::CTRL0_RESET;
      timer_cfg_ff          <= cst_pkg::TCFG_RESET;
    end else begin
      if (wr_ctrl) begin
        cap_sense_control0_ff <= hwdata[7:0] & cst_pkg::CTRL0_WR_MASK;
      end
      if (wr_tcfg) begin
        timer_cfg_ff <= hwdata[4:0];
      end
    end
  end

  // timers; a software write takes priority over a tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer0_ff <= '0;
      timer1_ff <= '0;
    end else begin
      if (wr_t0) begin
        timer0_ff <= hwdata[T0_W-1:0];
      end else if (t0_tick) begin
        timer0_ff <= timer0_ff + 1'b1;
      end
      if (wr_t1) begin
        timer1_ff <= hwdata[T1_W-1:0];
      end else if (t1_tick) begin
        timer1_ff <= timer1_ff + 1'b1;
      end
    end
  end

  // module outputs from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_module_enable <= 1'b0;
      osc_current_range   <= cst_pkg::RANGE_OFF;
    end else begin
      sense_module_enable <= cap_sense_control0_ff[cst_pkg::ENABLE_BIT];
      osc_current_range   <= mod_on ?
                             cap_sense_control0_ff[cst_pkg::RANGE_HI:cst_pkg::RANGE_LO] :
                             cst_pkg::RANGE_OFF;
    end
  end

  // bus response; never stalls and never errors, so the master waits one edge at most
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = hrdata_ff;

  // checks; a software write to a timer excuses that cycle from the counting rules
  t1_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!t1_on && !wr_t1) |=> $stable(timer1_ff))
    else $error("timer1 moved while off");
  t1_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (t1_on && t1_ge && !gate_sync_ff[1] && !wr_t1) |=> $stable(timer1_ff))
    else $error("timer1 moved with gate closed");
  t1_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (t1_tick && !wr_t1) |=> timer1_ff == $past(timer1_ff) + 1'b1)
    else $error("timer1 missed an oscillator edge");
  t0_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (t0_tick && !wr_t0) |=> timer0_ff == $past(timer0_ff) + 1'b1)
    else $error("timer0 missed an oscillator edge");
  t0_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_cfg_ff[cst_pkg::T0_CS_BIT] && !wr_t0) |=> $stable(timer0_ff))
    else $error("timer0 counted oscillator with core clock source");
  // a pin rise reaches the detector two edges later: two sync flops, then the compare
  sequence osc_pin_rise_s;
    !osc_in ##1 osc_in;
  endsequence
  edge_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!osc_rise && !wr_t1) |=> $stable(timer1_ff))
    else $error("timer1 moved without an oscillator edge");
  edge_seen_a: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_pin_rise_s |-> ##2 osc_rise)
    else $error("edge detector missed a rise");
  rsvd_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_req && a_ofs == cst_pkg::CTRL0_OFS) |=>
    hrdata[31:cst_pkg::ENABLE_BIT+1] == '0 &&
    hrdata[cst_pkg::ENABLE_BIT-1:cst_pkg::RANGE_HI+1] == '0)
    else $error("unimplemented control bits read nonzero");
  enable_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 sense_module_enable == $past(cap_sense_control0_ff[cst_pkg::ENABLE_BIT]))
    else $error("enable output wrong");
  range_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !mod_on |=> osc_current_range == cst_pkg::RANGE_OFF)
    else $error("range active while module disabled");
  range_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mod_on |=> osc_current_range ==
      $past(cap_sense_control0_ff[cst_pkg::RANGE_HI:cst_pkg::RANGE_LO]))
    else $error("range output does not follow the control field");
  dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_rd[cst_pkg::DIR_BIT] == (osc_run && $past(osc_sourcing, 2)))
    else $error("direction status wrong");
  ctrl_reset_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> cap_sense_control0_ff == cst_pkg::CTRL0_RESET &&
    timer_cfg_ff == cst_pkg::TCFG_RESET)
    else $error("control registers not clear after reset");
endmodule

// >>> verilog/cst_pkg.sv
// cst_pkg: constants for the capacitive sensing timer select block
// assumes a 32-bit ahb-lite bus and a single 20 MHz core clock
package cst_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL0_OFS     = 8'h00;
  localparam logic [7:0] TIMER_CFG_OFS = 8'h04;
  localparam logic [7:0] TIMER0_OFS    = 8'h08;
  localparam logic [7:0] TIMER1_OFS    = 8'h0C;
  // cap_sense_control0 field positions
  localparam int ENABLE_BIT    = 7;
  localparam int RANGE_HI      = 3;
  localparam int RANGE_LO      = 2;
  localparam int DIR_BIT       = 1;
  localparam int T0_SEL_BIT    = 0;
  localparam logic [7:0] CTRL0_RESET    = 8'h00;
  localparam logic [7:0] CTRL0_WR_MASK  = 8'h8D;
  // timer_config field positions
  localparam int T0_CS_BIT     = 0;
  localparam int T1_CS_LO      = 1;
  localparam int T1_CS_HI      = 2;
  localparam int T1_ON_BIT     = 3;
  localparam int T1_GE_BIT     = 4;
  localparam logic [4:0] TCFG_RESET     = 5'h00;
  localparam logic [1:0] T1_CS_OSC      = 2'h3;
  // oscillator current ranges
  localparam logic [1:0] RANGE_OFF  = 2'h0;
  localparam logic [1:0] RANGE_LOW  = 2'h1;
  localparam logic [1:0] RANGE_MED  = 2'h2;
  localparam logic [1:0] RANGE_HIGH = 2'h3;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// >>> dv/test_cst_top.sv
// test_cst_top: self-checking bench for the cap sense timer select block
// assumes the bench is the only ahb-lite master; hready is fed back from hreadyout
`timescale 1ns/1ns
module test_cst_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_in;
  logic        osc_sourcing;
  logic        t1_gate_in;
  logic        sense_module_enable;
  logic [1:0]  osc_current_range;
  logic [31:0] rd;
  logic        rsp;
  int          n_errors;
  int          tests_run;
  int          cycles;

  cst_top u_cst_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_in(osc_in),
    .osc_sourcing(osc_sourcing), .t1_gate_in(t1_gate_in),
    .sense_module_enable(sense_module_enable), .osc_current_range(osc_current_range));

  // 50 ns core clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // a hung handshake would stall forever; the ceiling is well above the whole run
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= cst_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rsp = hresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, {24'h0000_00, a}, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, {24'h0000_00, a}, d);
  endtask

  // each level held 3 cycles, above the 1-cycle minimum the synchroniser needs
  task automatic pulse(input int n);
    repeat (n) begin
      osc_in <= 1'b1;
      repeat (3) @(posedge hclk);
      osc_in <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    repeat (6) @(posedge hclk);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    {hresetn, hsel, hwrite, osc_in, osc_sourcing, t1_gate_in} = 6'h00;
    {haddr, hwdata, htrans, hsize, n_errors, tests_run, cycles} = '0;
    do_reset();
    rd_chk(cst_pkg::CTRL0_OFS, 32'h0000_0000);
    wr(cst_pkg::CTRL0_OFS, 32'h0000_00FF);
    rd_chk(cst_pkg::CTRL0_OFS, 32'h0000_008D);
    repeat (2) @(posedge hclk);
    check({31'h0, sense_module_enable}, 32'h0000_0001);
    // every current range reaches the pin; bit 1 stays read-only
    for (int r = 0; r < 4; r++) begin
      wr(cst_pkg::CTRL0_OFS, 32'h0000_0082 | (r << 2));
      repeat (2) @(posedge hclk);
      check({30'h0, osc_current_range}, r);
    end
    osc_sourcing <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk(cst_pkg::CTRL0_OFS, 32'h0000_008E);
    osc_sourcing <= 1'b0;
    repeat (4) @(posedge hclk);
    rd_chk(cst_pkg::CTRL0_OFS, 32'h0000_008C);
    wr(cst_pkg::CTRL0_OFS, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    check({31'h0, sense_module_enable}, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    check({31'h0000_0000, rsp}, 32'h0000_0000);
    // timer0 on the oscillator, then deselected, then module off
    wr(cst_pkg::CTRL0_OFS, 32'h0000_0085);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_0000);
    wr(cst_pkg::TIMER0_OFS, 32'h0000_0000);
    pulse(5);
    rd_chk(cst_pkg::TIMER0_OFS, 32'h0000_0005);
    // core clock source for timer0 keeps the oscillator away from it
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_0001);
    pulse(3);
    rd_chk(cst_pkg::TIMER0_OFS, 32'h0000_0005);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_0000);
    wr(cst_pkg::CTRL0_OFS, 32'h0000_0084);
    pulse(3);
    rd_chk(cst_pkg::TIMER0_OFS, 32'h0000_0005);
    wr(cst_pkg::CTRL0_OFS, 32'h0000_0005);
    pulse(2);
    rd_chk(cst_pkg::TIMER0_OFS, 32'h0000_0005);
    // timer1 wraps through its top value while free running
    wr(cst_pkg::CTRL0_OFS, 32'h0000_0084);
    wr(cst_pkg::TIMER1_OFS, 32'h0000_FFFE);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_000E);
    pulse(3);
    rd_chk(cst_pkg::TIMER1_OFS, 32'h0000_0001);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_0016);
    pulse(2);
    rd_chk(cst_pkg::TIMER1_OFS, 32'h0000_0001);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_001E);
    pulse(2);
    rd_chk(cst_pkg::TIMER1_OFS, 32'h0000_0001);
    // gate level stands in for the window software builds from timer0 overflow
    t1_gate_in <= 1'b1;
    repeat (4) @(posedge hclk);
    pulse(4);
    rd_chk(cst_pkg::TIMER1_OFS, 32'h0000_0005);
    wr(cst_pkg::TIMER_CFG_OFS, 32'h0000_000C);
    pulse(2);
    rd_chk(cst_pkg::TIMER1_OFS, 32'h0000_0005);
    // a second reset in mid-run clears the control register again
    wr(cst_pkg::CTRL0_OFS, 32'h0000_008D);
    do_reset();
    rd_chk(cst_pkg::CTRL0_OFS, 32'h0000_0000);
    rd_chk(cst_pkg::TIMER_CFG_OFS, 32'h0000_0000);
    final_report();
  end
endmodule
